//--- mpms_sequencer.sv
// Summary of operation
// R1: cellular starts in, and returns to, not-powered while supply is absent
// R2: with supply valid, stay in power-off until the control line toggles
// R3: a toggle runs the switch-on routine, then active mode
// R4: active has interfaces ready; radio activity moves to connected mode
// R5: active drops to idle only when low-power config is enabled
// R6: idle length depends on low-power setting, reception setting, activity
// R7: idle runs processor slow, active full speed, connected enables radio
// R8: power-off command or toggle while running does a graceful switch-off
// R9: cyclic-tracking save keeps receiver partly on between fixes
// R10: on/off save alternates navigation with backup/sleep phases
// R11: host should disable augmentation reception in save mode
// R12: receiver enters hardware backup when its main supply is removed
// R13: backup or standby keeps time and navigation data
// R14: host enters standby with the power-request message force flag set
// R15: entering standby clears RAM; battery-backed settings survive
// R16: standby disables core and radio supplies, keeps I/O domain
// R17: standby ends after its duration or at the wake source
// R18: second general pin switches receiver power when so configured
// R19: receiver data-ready wakes cellular side from idle
// R20: relay to receiver only while the cellular side is operating
// R21: control line ignored while not-powered
`timescale 1ns/1ns
`include "mpms_consts.svh"
module mpms_sequencer (
	input  wire logic               hclk,
	input  wire logic               hresetn,
	input  wire logic               hsel,
	input  wire logic [31:0]        haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic [31:0]        hwdata,
	input  wire logic               hready,
	output logic [31:0]             hrdata,
	output logic                    hreadyout,
	output logic                    hresp,
	input  wire mpms_pkg::mpms_pins_t pins,
	output mpms_pkg::mpms_outs_t    outs
);
	mpms_pkg::mpms_pins_t s1_reg, s2_reg;
	logic pwr_last_reg;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			s1_reg <= '0;
			s2_reg <= '0;
			pwr_last_reg <= 1'b0;
		end
		else
		begin
			s1_reg <= pins;
			s2_reg <= s1_reg;
			pwr_last_reg <= s2_reg.power_on_control_line;
		end
	end
	logic toggle;
	assign toggle = s2_reg.power_on_control_line & ~pwr_last_reg;

	// bus slave: registered address phase, zero wait states
	logic        wr_reg, wr_next;
	logic [7:0]  wa_reg, wa_next;
	logic [31:0] ctrl_reg, ctrl_next;
	logic [15:0] dur_reg, dur_next;
	logic [31:0] rd_reg, rd_next;
	logic        off_req, sby_req, radio_cmd, gnss_cmd, force_bit;
	logic        valid;
	mpms_pkg::mpms_cell_t cell_reg, cell_next;
	mpms_pkg::mpms_gnss_t gnss_reg, gnss_next;
	logic [15:0] cnt_reg, cnt_next;
	logic [15:0] scnt_reg, scnt_next;
	logic        busy_reg, busy_next;
	logic        radio_reg, radio_next;
	logic        genable_reg, genable_next;
	mpms_pkg::mpms_outs_t outs_reg, outs_next;
	assign valid = hsel & hready & htrans[1];
	always_comb
	begin
		wr_next   = valid & hwrite;
		wa_next   = valid ? haddr[7:0] : wa_reg;
		ctrl_next = ctrl_reg;
		dur_next  = dur_reg;
		off_req   = 1'b0;
		sby_req   = 1'b0;
		radio_cmd = radio_reg;
		gnss_cmd  = genable_reg;
		force_bit = 1'b0;
		if (wr_reg)
		begin
			case (wa_reg)
				`MPMS_A_CTRL:    ctrl_next = hwdata;
				`MPMS_A_SBY_DUR: dur_next = hwdata[15:0];
				`MPMS_A_CMD:
				begin
					off_req   = hwdata[`MPMS_CMD_OFF];
					force_bit = hwdata[`MPMS_CMD_FORCE];
					sby_req   = hwdata[`MPMS_CMD_SBY] & force_bit; // R14
					radio_cmd = hwdata[`MPMS_CMD_RADIO];
					gnss_cmd  = hwdata[`MPMS_CMD_GNSS_EN];
				end
				default: ;
			endcase
		end
		rd_next = 32'h0000_0000;
		if (valid & ~hwrite)
		begin
			case (haddr[7:0])
				`MPMS_A_CTRL:    rd_next = ctrl_reg;
				`MPMS_A_SBY_DUR: rd_next = {16'h0000, dur_reg};
				`MPMS_A_STATUS:  rd_next = {27'h000_0000, cell_reg};
				`MPMS_A_GSTAT:   rd_next = {28'h000_0000, gnss_reg};
				default:         rd_next = 32'h0000_0000;
			endcase
		end
	end
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_reg   <= 1'b0;
			wa_reg   <= 8'h00;
			ctrl_reg <= `MPMS_CTRL_RST;
			dur_reg  <= 16'h0000;
			rd_reg   <= 32'h0000_0000;
		end
		else
		begin
			wr_reg   <= wr_next;
			wa_reg   <= wa_next;
			ctrl_reg <= ctrl_next;
			dur_reg  <= dur_next;
			rd_reg   <= rd_next;
		end
	end
	assign hrdata    = rd_reg;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// cellular mode machine
	logic lp_en, pin_sel, wake_sel;
	logic [1:0] gmode;
	assign lp_en    = ctrl_reg[`MPMS_CTRL_LP];
	assign pin_sel  = ctrl_reg[`MPMS_CTRL_PINSEL];
	assign gmode    = ctrl_reg[`MPMS_CTRL_GMODE +: 2];
	assign wake_sel = ctrl_reg[`MPMS_CTRL_WAKESEL];
	logic activity;
	assign activity = s2_reg.radio_activity | radio_reg;
	always_comb
	begin
		cell_next  = cell_reg;
		cnt_next   = cnt_reg;
		busy_next  = busy_reg;
		radio_next = radio_cmd;
		if (!s2_reg.cell_supply_ok)
		begin
			cell_next = mpms_pkg::MPMS_NOPWR; // R1 R21
			busy_next = 1'b0;
			cnt_next  = 16'h0000;
		end
		else if (busy_reg)
		begin
			if (cnt_reg == 16'h0000)
			begin
				busy_next = 1'b0;
				cell_next = (cell_reg == mpms_pkg::MPMS_OFF) ?
					mpms_pkg::MPMS_ACTIVE : mpms_pkg::MPMS_OFF; // R3 R8
			end
			else
				cnt_next = cnt_reg - 16'h0001;
		end
		else
		begin
			case (cell_reg)
				mpms_pkg::MPMS_NOPWR: cell_next = mpms_pkg::MPMS_OFF; // R2
				mpms_pkg::MPMS_OFF:
					if (toggle) // R2 R3 R21
					begin
						busy_next = 1'b1;
						cnt_next  = 16'(`MPMS_BOOT_CYC);
					end
				mpms_pkg::MPMS_ACTIVE, mpms_pkg::MPMS_CONN,
				mpms_pkg::MPMS_IDLE:
				begin
					if (off_req | toggle) // R8
					begin
						busy_next = 1'b1;
						cnt_next  = 16'(`MPMS_OFF_CYC);
					end
					else if (activity)
						cell_next = mpms_pkg::MPMS_CONN; // R4
					else if (cell_reg == mpms_pkg::MPMS_IDLE)
					begin
						if (s2_reg.gnss_data_ready | ~lp_en |
						    cnt_reg == 16'h0000) // R19 R6
							cell_next = mpms_pkg::MPMS_ACTIVE;
						else
							cnt_next = cnt_reg - 16'h0001;
					end
					else if (lp_en & ~s2_reg.gnss_data_ready)
					begin
						cell_next = mpms_pkg::MPMS_IDLE; // R5
						cnt_next  = `MPMS_IDLE_BASE + dur_reg; // R6
					end
					else
						cell_next = mpms_pkg::MPMS_ACTIVE;
				end
				default: cell_next = mpms_pkg::MPMS_NOPWR;
			endcase
		end
	end

	// receiver machine
	logic cell_on;
	assign cell_on = cell_reg == mpms_pkg::MPMS_ACTIVE ||
		cell_reg == mpms_pkg::MPMS_IDLE || cell_reg == mpms_pkg::MPMS_CONN;
	always_comb
	begin
		gnss_next    = gnss_reg;
		scnt_next    = scnt_reg;
		genable_next = gnss_cmd;
		case (gnss_reg)
			mpms_pkg::MPMS_G_DOWN:
				if (s2_reg.gnss_main_ok)
					gnss_next = mpms_pkg::MPMS_G_RUN;
				else if (s2_reg.gnss_backup_ok)
					gnss_next = mpms_pkg::MPMS_G_HWBK;
			mpms_pkg::MPMS_G_RUN:
				if (!s2_reg.gnss_main_ok)
					gnss_next = s2_reg.gnss_backup_ok ?
						mpms_pkg::MPMS_G_HWBK : mpms_pkg::MPMS_G_DOWN; // R12
				else if (sby_req & cell_on) // R20
				begin
					gnss_next = mpms_pkg::MPMS_G_SBY; // R15
					scnt_next = dur_reg;
				end
			mpms_pkg::MPMS_G_HWBK:
				if (s2_reg.gnss_main_ok)
					gnss_next = mpms_pkg::MPMS_G_RUN;
				else if (!s2_reg.gnss_backup_ok)
					gnss_next = mpms_pkg::MPMS_G_DOWN;
			mpms_pkg::MPMS_G_SBY:
				if (!s2_reg.gnss_main_ok)
					gnss_next = mpms_pkg::MPMS_G_HWBK;
				else if ((wake_sel & s2_reg.external_wake_input) |
				         scnt_reg == 16'h0000) // R17
					gnss_next = mpms_pkg::MPMS_G_RUN;
				else
					scnt_next = scnt_reg - 16'h0001;
			default: gnss_next = mpms_pkg::MPMS_G_DOWN;
		endcase
	end

	// outputs; save modes only shape core gating while running
	logic ct_on, oo_on;
	assign ct_on = gmode == mpms_pkg::MPMS_GM_CT; // R9
	assign oo_on = gmode == mpms_pkg::MPMS_GM_OO &
		~s2_reg.gnss_data_ready; // R10
	always_comb
	begin
		outs_next = '0;
		outs_next.proc_full_speed = cell_reg == mpms_pkg::MPMS_ACTIVE ||
			cell_reg == mpms_pkg::MPMS_CONN; // R7
		outs_next.radio_enable = cell_reg == mpms_pkg::MPMS_CONN; // R7
		outs_next.ifaces_ready = cell_on & ~busy_reg; // R4
		outs_next.general_pin_two = pin_sel & cell_on & genable_reg; // R18
		// cyclic tracking never fully shuts the core between fixes
		outs_next.gnss_core_enable = gnss_reg == mpms_pkg::MPMS_G_RUN &
			(ct_on | ~oo_on); // R16 R10 R9
		outs_next.gnss_ram_clear = gnss_next == mpms_pkg::MPMS_G_SBY &
			gnss_reg != mpms_pkg::MPMS_G_SBY; // R15
		outs_next.gnss_backup_keep = gnss_reg == mpms_pkg::MPMS_G_SBY ||
			gnss_reg == mpms_pkg::MPMS_G_HWBK; // R13
		outs_next.relay_enable = cell_on; // R20
	end
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cell_reg    <= mpms_pkg::MPMS_NOPWR;
			gnss_reg    <= mpms_pkg::MPMS_G_DOWN;
			cnt_reg     <= 16'h0000;
			scnt_reg    <= 16'h0000;
			busy_reg    <= 1'b0;
			radio_reg   <= 1'b0;
			genable_reg <= 1'b0;
			outs_reg    <= '0;
		end
		else
		begin
			cell_reg    <= cell_next;
			gnss_reg    <= gnss_next;
			cnt_reg     <= cnt_next;
			scnt_reg    <= scnt_next;
			busy_reg    <= busy_next;
			radio_reg   <= radio_next;
			genable_reg <= genable_next;
			outs_reg    <= outs_next;
		end
	end
	assign outs = outs_reg;

	a_nopwr_hold: assert property ( // R1
		@(posedge hclk) disable iff (!hresetn)
		!s2_reg.cell_supply_ok |=> cell_reg == mpms_pkg::MPMS_NOPWR)
		else $error("supply loss not seen");
	a_off_wait: assert property ( // R2
		@(posedge hclk) disable iff (!hresetn)
		cell_reg == mpms_pkg::MPMS_OFF && !busy_reg && !toggle &&
		s2_reg.cell_supply_ok |=> cell_reg == mpms_pkg::MPMS_OFF)
		else $error("left power-off without toggle");
	a_boot_done: assert property ( // R3
		@(posedge hclk) disable iff (!hresetn)
		cell_reg == mpms_pkg::MPMS_OFF && toggle && !busy_reg |=>
		busy_reg ##[1:20] (cell_reg == mpms_pkg::MPMS_ACTIVE ||
		cell_reg == mpms_pkg::MPMS_NOPWR))
		else $error("switch-on did not finish");
	a_idle_gate: assert property ( // R5
		@(posedge hclk) disable iff (!hresetn)
		cell_reg != mpms_pkg::MPMS_IDLE ##1
		cell_reg == mpms_pkg::MPMS_IDLE |-> $past(lp_en))
		else $error("idle without low power");
	a_radio_conn: assert property ( // R7
		@(posedge hclk) disable iff (!hresetn)
		outs.radio_enable |-> $past(cell_reg) == mpms_pkg::MPMS_CONN)
		else $error("radio outside connected");
	a_hw_backup: assert property ( // R12
		@(posedge hclk) disable iff (!hresetn)
		gnss_reg == mpms_pkg::MPMS_G_RUN && !s2_reg.gnss_main_ok &&
		s2_reg.gnss_backup_ok |=> gnss_reg == mpms_pkg::MPMS_G_HWBK)
		else $error("no hardware backup");
	a_sby_core: assert property ( // R16
		@(posedge hclk) disable iff (!hresetn)
		gnss_reg == mpms_pkg::MPMS_G_SBY |=> !outs.gnss_core_enable)
		else $error("core on in standby");
	a_wake_idle: assert property ( // R19
		@(posedge hclk) disable iff (!hresetn)
		cell_reg == mpms_pkg::MPMS_IDLE && s2_reg.gnss_data_ready &&
		!busy_reg && s2_reg.cell_supply_ok && !toggle && !off_req &&
		!activity |=> cell_reg == mpms_pkg::MPMS_ACTIVE)
		else $error("data ready did not wake");
	// on/off sleep phase gates the core until data ready reopens it
	a_onoff_core: assert property ( // R10
		@(posedge hclk) disable iff (!hresetn)
		oo_on |=> !outs.gnss_core_enable)
		else $error("core on during on/off sleep");
	a_sby_cell: assert property ( // R20
		@(posedge hclk) disable iff (!hresetn)
		gnss_reg == mpms_pkg::MPMS_G_RUN ##1
		gnss_reg == mpms_pkg::MPMS_G_SBY |-> $past(cell_on))
		else $error("standby relayed while cellular off");
endmodule : mpms_sequencer

//--- mpms_consts.svh
`ifndef MPMS_CONSTS_SVH
`define MPMS_CONSTS_SVH
`define MPMS_A_CTRL       8'h00
`define MPMS_A_CMD        8'h04
`define MPMS_A_SBY_DUR    8'h08
`define MPMS_A_STATUS     8'h0C
`define MPMS_A_GNSS       8'h10
`define MPMS_A_GSTAT      8'h14
`define MPMS_CTRL_LP      0
`define MPMS_CTRL_PINSEL  1
`define MPMS_CTRL_GMODE   2
`define MPMS_CTRL_WAKESEL 4
`define MPMS_CMD_OFF      0
`define MPMS_CMD_SBY      1
`define MPMS_CMD_FORCE    2
`define MPMS_CMD_RADIO    3
`define MPMS_CMD_GNSS_EN  4
`define MPMS_CTRL_RST     32'h0000_0000
`define MPMS_BOOT_NS      40
`define MPMS_BOOT_CYC     ((`MPMS_BOOT_NS + 3) / 4)
`define MPMS_OFF_NS       40
`define MPMS_OFF_CYC      ((`MPMS_OFF_NS + 3) / 4)
`define MPMS_IDLE_BASE    16'h0010
`endif

//--- mpms_pkg.sv
package mpms_pkg;
	typedef enum logic [4:0] {
		MPMS_NOPWR  = 5'b0_0001,
		MPMS_OFF    = 5'b0_0010,
		MPMS_ACTIVE = 5'b0_0100,
		MPMS_IDLE   = 5'b0_1000,
		MPMS_CONN   = 5'b1_0000
	} mpms_cell_t;
	typedef enum logic [3:0] {
		MPMS_G_DOWN = 4'b0001,
		MPMS_G_RUN  = 4'b0010,
		MPMS_G_HWBK = 4'b0100,
		MPMS_G_SBY  = 4'b1000
	} mpms_gnss_t;
	typedef enum logic [1:0] {
		MPMS_GM_CONT = 2'b00,
		MPMS_GM_CT   = 2'b01,
		MPMS_GM_OO   = 2'b10
	} mpms_gmode_t;
	typedef struct packed {
		logic cell_supply_ok;
		logic gnss_main_ok;
		logic gnss_backup_ok;
		logic power_on_control_line;
		logic external_wake_input;
		logic gnss_data_ready;
		logic radio_activity;
	} mpms_pins_t;
	typedef struct packed {
		logic       proc_full_speed;
		logic       radio_enable;
		logic       ifaces_ready;
		logic       general_pin_two;
		logic       gnss_core_enable;
		logic       gnss_ram_clear;
		logic       gnss_backup_keep;
		logic       relay_enable;
	} mpms_outs_t;
endpackage : mpms_pkg

//--- mpms_host_model.sv
`timescale 1ns/1ns
module mpms_host_model (
	input  wire logic            hclk,
	output mpms_pkg::mpms_pins_t pins
);
	initial
	begin
		pins = '0;
	end
	// held six cycles so the synchroniser and edge detector both see it
	task automatic toggle();
		@(posedge hclk);
		pins.power_on_control_line <= 1'b1;
		repeat (6) @(posedge hclk);
		pins.power_on_control_line <= 1'b0;
		repeat (6) @(posedge hclk);
	endtask : toggle
	task automatic set_pin(input int idx, input logic v);
		@(posedge hclk);
		pins[idx] <= v;
	endtask : set_pin
endmodule : mpms_host_model

//--- tb_mpms_sequencer.sv
`timescale 1ns/1ns
`include "mpms_consts.svh"
module tb_mpms_sequencer;
	localparam int          CELL = 6;
	localparam int          GMAIN = 5;
	localparam int          GBACK = 4;
	localparam int          WAKE = 2;
	localparam int          RDY = 1;
	localparam int          RADIO = 0;
	localparam logic [31:0] B1 = 32'h0000_0001;
	logic                   hclk;
	logic                   hresetn;
	logic                   hsel;
	logic                   hwrite;
	logic                   hready;
	logic                   hreadyout;
	logic                   hresp;
	logic [31:0]            haddr;
	logic [31:0]            hwdata;
	logic [31:0]            hrdata;
	logic [31:0]            rd;
	logic [31:0]            en;
	logic [31:0]            cw;
	logic [1:0]             htrans;
	logic [2:0]             hsize;
	mpms_pkg::mpms_pins_t   pins;
	mpms_pkg::mpms_outs_t   outs;
	int                     fails;
	int                     tests_run;
	int                     clears;
	assign hready = hreadyout;
	mpms_sequencer i_mpms_sequencer (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .pins(pins), .outs(outs));
	mpms_host_model i_mpms_host_model (.hclk(hclk), .pins(pins));
	initial
	begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end
	// a one-cycle pulse is easy to miss by polling, so count it here
	always @(posedge hclk)
	begin
		if (outs.gnss_ram_clear === 1'b1)
			clears <= clears + 1;
	end
	task automatic results();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : results
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic bus(input logic [7:0] a, input logic w,
		input logic [31:0] d);
		int n;
		n = 0;
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		htrans <= 2'b10;
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1 && n < 50)
		begin
			n++;
			@(posedge hclk);
		end
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1 && n < 50)
		begin
			n++;
			@(posedge hclk);
		end
		rd = hrdata;
		if (n >= 50)
		begin
			fails++;
			$display("[FAIL] hready expected 1 seen %b", hreadyout);
			results();
		end
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(a, 1'b1, d);
	endtask : wr
	task automatic poll(input string nm, input logic [7:0] a,
		input logic [31:0] e, input int lim);
		int n;
		n = 0;
		bus(a, 1'b0, 32'h0000_0000);
		while (rd !== e && n < lim)
		begin
			n++;
			bus(a, 1'b0, 32'h0000_0000);
		end
		chk(nm, e, rd);
	endtask : poll
	task automatic pin(input int idx, input logic v);
		i_mpms_host_model.set_pin(idx, v);
	endtask : pin
	initial
	begin
		#200000;
		fails++;
		$display("[FAIL] run expected end seen timeout");
		results();
	end
	initial
	begin
		fails = 0;
		tests_run = 0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = '0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = '0;
		en = B1 << `MPMS_CMD_GNSS_EN;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		poll("cell", `MPMS_A_STATUS, mpms_pkg::MPMS_NOPWR, 0);
		poll("gnss", `MPMS_A_GSTAT, mpms_pkg::MPMS_G_DOWN, 0);
		poll("ctrl", `MPMS_A_CTRL, `MPMS_CTRL_RST, 0);
		poll("unmapped", 8'h18, 32'h0000_0000, 0);
		chk("outs", 32'h0000_0000, outs);
		chk("hresp", 32'h0000_0000, hresp);
		i_mpms_host_model.toggle();
		poll("cell", `MPMS_A_STATUS, mpms_pkg::MPMS_NOPWR, 0);
		pin(CELL, 1'b1);
		poll("cell", `MPMS_A_STATUS, mpms_pkg::MPMS_OFF, 20);
		repeat (20) @(posedge hclk);
		poll("cell", `MPMS_A_STATUS, mpms_pkg::MPMS_OFF, 0);
		i_mpms_host_model.toggle();
		poll("cell", `MPMS_A_STATUS, mpms_pkg::MPMS_ACTIVE, 20);
		chk("ifaces", 1, outs.ifaces_ready);
		chk("speed", 1, outs.proc_full_speed);
		chk("relay", 1, outs.relay_enable);
		pin(RADIO, 1'b1);
		poll("cell", `MPMS_A_STATUS, mpms_pkg::MPMS_CONN, 10);
		chk("radio", 1, outs.radio_enable);
		pin(RADIO, 1'b0);
		poll("cell", `MPMS_A_STATUS, mpms_pkg::MPMS_ACTIVE, 10);
		wr(`MPMS_A_SBY_DUR, 32'h0000_0100);
		wr(`MPMS_A_CTRL, B1 << `MPMS_CTRL_LP);
		poll("cell", `MPMS_A_STATUS, mpms_pkg::MPMS_IDLE, 20);
		chk("speed", 0, outs.proc_full_speed);
		pin(RDY, 1'b1);
		poll("cell", `MPMS_A_STATUS, mpms_pkg::MPMS_ACTIVE, 8);
		pin(RDY, 1'b0);
		wr(`MPMS_A_CTRL, (B1 << `MPMS_CTRL_PINSEL) | (B1 << `MPMS_CTRL_WAKESEL));
		poll("cell", `MPMS_A_STATUS, mpms_pkg::MPMS_ACTIVE, 200);
		pin(GBACK, 1'b1);
		pin(GMAIN, 1'b1);
		wr(`MPMS_A_CMD, en);
		repeat (3) @(posedge hclk);
		chk("pin_two", 1, outs.general_pin_two);
		poll("gnss", `MPMS_A_GSTAT, mpms_pkg::MPMS_G_RUN, 20);
		wr(`MPMS_A_CMD, en | (B1 << `MPMS_CMD_SBY));
		repeat (3) @(posedge hclk);
		poll("gnss", `MPMS_A_GSTAT, mpms_pkg::MPMS_G_RUN, 0);
		wr(`MPMS_A_SBY_DUR, 32'h0000_1000);
		en = en | (B1 << `MPMS_CMD_SBY) | (B1 << `MPMS_CMD_FORCE);
		wr(`MPMS_A_CMD, en);
		poll("gnss", `MPMS_A_GSTAT, mpms_pkg::MPMS_G_SBY, 10);
		chk("core", 0, outs.gnss_core_enable);
		chk("keep", 1, outs.gnss_backup_keep);
		pin(WAKE, 1'b1);
		poll("gnss", `MPMS_A_GSTAT, mpms_pkg::MPMS_G_RUN, 10);
		pin(WAKE, 1'b0);
		wr(`MPMS_A_SBY_DUR, 32'h0000_0020);
		wr(`MPMS_A_CMD, en);
		poll("gnss", `MPMS_A_GSTAT, mpms_pkg::MPMS_G_SBY, 10);
		poll("gnss", `MPMS_A_GSTAT, mpms_pkg::MPMS_G_RUN, 60);
		chk("ram_clear", 2, clears);
		cw = (B1 << `MPMS_CTRL_PINSEL) | (B1 << `MPMS_CTRL_WAKESEL);
		wr(`MPMS_A_CTRL, cw | (B1 << (`MPMS_CTRL_GMODE + 1)));
		repeat (2) @(posedge hclk);
		chk("core", 0, outs.gnss_core_enable);
		wr(`MPMS_A_CTRL, cw | (B1 << `MPMS_CTRL_GMODE));
		repeat (2) @(posedge hclk);
		chk("core", 1, outs.gnss_core_enable);
		pin(GMAIN, 1'b0);
		poll("gnss", `MPMS_A_GSTAT, mpms_pkg::MPMS_G_HWBK, 10);
		chk("keep", 1, outs.gnss_backup_keep);
		wr(`MPMS_A_CMD, B1 << `MPMS_CMD_OFF);
		poll("cell", `MPMS_A_STATUS, mpms_pkg::MPMS_OFF, 30);
		chk("relay", 0, outs.relay_enable);
		i_mpms_host_model.toggle();
		poll("cell", `MPMS_A_STATUS, mpms_pkg::MPMS_ACTIVE, 20);
		i_mpms_host_model.toggle();
		poll("cell", `MPMS_A_STATUS, mpms_pkg::MPMS_OFF, 30);
		pin(CELL, 1'b0);
		poll("cell", `MPMS_A_STATUS, mpms_pkg::MPMS_NOPWR, 10);
		results();
	end
endmodule : tb_mpms_sequencer
